// File: verilog/psr_rx_status.sv
// PS/2 receive status, error detection and clock hold with APB registers
// Operation
// - The parity bit is taken from the data line at the tenth falling clock edge.
// - A parity mismatch in even or odd mode sets parity error and timeout and interrupts.
// - After a timeout the clock line is held low at least 300 us and until status is read.
// - A gap over 300 us between falling clock edges in a frame sets the timeout flag.
// - More than 2 ms from start bit to parity bit sets the timeout flag.
// - Parity and framing errors also set the timeout flag.
// - Timeout detection works only while the channel is enabled.
// - A rise of the timeout or byte ready flag raises an activity interrupt.
// - An error-free frame sets byte ready after its eleventh falling edge.
// - Clearing the channel enable after the tenth edge also sets byte ready.
// - Reading the receive data register clears byte ready, which is read-only.
// - A wrong stop bit at the eleventh edge sets framing error and timeout and interrupts.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "psr_params.svh"
module psr_rx_status
  import psr_pkg::*;
#(
  parameter int unsigned BIT_CYC = `PSR_BIT_US * `PSR_CLK_MHZ,
  parameter int unsigned FRAME_CYC = `PSR_FRAME_MS * 1000 * `PSR_CLK_MHZ,
  parameter int unsigned HOLD_CYC = `PSR_HOLD_US * `PSR_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ps2_clk_in,
  input wire logic ps2_dat_in,
  output logic ps2_clk_out,
  output logic ps2_clk_oe_n,
  output logic irq
);
  localparam logic [`PSR_TW-1:0] BIT_LIM = `PSR_TW'(BIT_CYC);
  localparam logic [`PSR_TW-1:0] FRAME_LIM = `PSR_TW'(FRAME_CYC);
  localparam logic [`PSR_TW-1:0] HOLD_LIM = `PSR_TW'(HOLD_CYC);

  logic clk_q1_ff, clk_q2_ff, clk_q3_ff, dat_q1_ff, dat_q2_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff, irq_ff, clk_out_ff, clk_oe_n_ff;
  psr_ctrl_t ctrl_ff;
  psr_stat_t stat_ff;
  psr_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [`PSR_TW-1:0] bit_tmr_ff, frame_tmr_ff, hold_tmr_ff;
  logic read_seen_ff;
  logic [`PSR_INT_W-1:0] ist_ff, imsk_ff, ist_set;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign ps2_clk_out = clk_out_ff;
  assign ps2_clk_oe_n = clk_oe_n_ff;

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q1_ff <= 1'b1;
      clk_q2_ff <= 1'b1;
      clk_q3_ff <= 1'b1;
      dat_q1_ff <= 1'b1;
      dat_q2_ff <= 1'b1;
    end else begin
      clk_q1_ff <= ps2_clk_in;
      clk_q2_ff <= clk_q1_ff;
      clk_q3_ff <= clk_q2_ff;
      dat_q1_ff <= ps2_dat_in;
      dat_q2_ff <= dat_q1_ff;
    end
  end

  wire fall = clk_q3_ff & ~clk_q2_ff;
  wire recv = (state_ff == st_recv);
  wire en = ctrl_ff.channel_enable;
  wire rx_fall = recv & fall & en;

  // APB decode
  wire sel_data = (paddr == `PSR_OFS_DATA);
  wire sel_ctrl = (paddr == `PSR_OFS_CTRL);
  wire sel_stat = (paddr == `PSR_OFS_STAT);
  wire sel_ist = (paddr == `PSR_OFS_IST);
  wire sel_imsk = (paddr == `PSR_OFS_IMSK);
  wire hit = sel_data | sel_ctrl | sel_stat | sel_ist | sel_imsk;
  wire acc = psel & penable & ~pready_ff;
  wire done = psel & penable & pready_ff;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;

  // Frame events
  wire tenth = rx_fall & (cnt_ff == `PSR_CNT_PAR);
  wire eleventh = rx_fall & (cnt_ff == `PSR_CNT_STOP);
  wire par_xor = ^{shift_ff, dat_q2_ff};
  wire par_err = tenth & (((ctrl_ff.par_mode == `PSR_PAR_EVEN) & par_xor) |
                 ((ctrl_ff.par_mode == `PSR_PAR_ODD) & ~par_xor));
  wire stop_err = eleventh & (((ctrl_ff.stop_mode == `PSR_STOP_HIGH) & ~dat_q2_ff) |
                  ((ctrl_ff.stop_mode == `PSR_STOP_LOW) & dat_q2_ff));
  wire bit_tmo = recv & ~fall & (bit_tmr_ff == BIT_LIM);
  wire frame_tmo = recv & ~fall & (cnt_ff <= `PSR_CNT_PAR) &
                   (frame_tmr_ff == FRAME_LIM);
  wire tmo_ev = (en & (bit_tmo | frame_tmo)) | par_err | stop_err;
  wire rdy_ev = (eleventh & ~stop_err) |
                (recv & ~en & (cnt_ff == `PSR_CNT_STOP));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~hit;
      if (acc) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (sel_data) begin
      nxt_prdata[7:0] = shift_ff;
    end
    if (sel_ctrl) begin
      nxt_prdata[`PSR_CTRL_W-1:0] = ctrl_ff;
    end
    if (sel_stat) begin
      nxt_prdata[`PSR_ST_FE:`PSR_ST_RDY] = stat_ff;
      nxt_prdata[`PSR_ST_BUSY] = recv;
    end
    if (sel_ist) begin
      nxt_prdata[`PSR_INT_W-1:0] = ist_ff;
    end
    if (sel_imsk) begin
      nxt_prdata[`PSR_INT_W-1:0] = imsk_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '0;
      imsk_ff <= '0;
    end else if (wr) begin
      if (sel_ctrl) begin
        ctrl_ff <= psr_ctrl_t'(pwdata[`PSR_CTRL_W-1:0]);
      end
      if (sel_imsk) begin
        imsk_ff <= pwdata[`PSR_INT_W-1:0];
      end
    end
  end

  // Receive state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= st_idle;
      cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        st_idle: begin
          if (en && fall) begin
            state_ff <= st_recv;
            cnt_ff <= `PSR_CNT_START;
          end
        end
        st_recv: begin
          if (tmo_ev) begin
            state_ff <= st_hold;
          end else if (!en || eleventh) begin
            state_ff <= st_idle;
          end else if (fall) begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        st_hold: begin
          if (hold_tmr_ff == HOLD_LIM && read_seen_ff) begin
            state_ff <= st_idle;
          end
        end
        default: state_ff <= st_idle;
      endcase
    end
  end

  // Data bits arrive LSB first on edges two to nine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff <= 8'h00;
    end else if (rx_fall && cnt_ff <= `PSR_CNT_LAST_DATA) begin
      shift_ff <= {dat_q2_ff, shift_ff[7:1]};
    end
  end

  // Saturating timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_tmr_ff <= '0;
      frame_tmr_ff <= '0;
      hold_tmr_ff <= '0;
      read_seen_ff <= 1'b0;
    end else begin
      if (!recv || fall) begin
        bit_tmr_ff <= '0;
      end else if (bit_tmr_ff != BIT_LIM) begin
        bit_tmr_ff <= bit_tmr_ff + 1'b1;
      end
      if (!recv) begin
        frame_tmr_ff <= '0;
      end else if (frame_tmr_ff != FRAME_LIM) begin
        frame_tmr_ff <= frame_tmr_ff + 1'b1;
      end
      if (state_ff != st_hold) begin
        hold_tmr_ff <= '0;
        read_seen_ff <= 1'b0;
      end else begin
        if (hold_tmr_ff != HOLD_LIM) begin
          hold_tmr_ff <= hold_tmr_ff + 1'b1;
        end
        if (rd && sel_stat) begin
          read_seen_ff <= 1'b1;
        end
      end
    end
  end

  // Status flags; a set in the clearing cycle wins
  wire w1c = wr & sel_stat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
    end else begin
      stat_ff.byte_ready <= rdy_ev | (stat_ff.byte_ready & ~(rd & sel_data));
      stat_ff.receive_timeout_flag <= tmo_ev |
        (stat_ff.receive_timeout_flag & ~(w1c & pwdata[`PSR_ST_TMO]));
      stat_ff.parity_error_flag <= par_err |
        (stat_ff.parity_error_flag & ~(w1c & pwdata[`PSR_ST_PE]));
      stat_ff.framing_error_flag <= stop_err |
        (stat_ff.framing_error_flag & ~(w1c & pwdata[`PSR_ST_FE]));
    end
  end

  // Interrupt status: activity, parity, framing
  assign ist_set = {stop_err, par_err,
    (tmo_ev & ~stat_ff.receive_timeout_flag) | (rdy_ev & ~stat_ff.byte_ready)};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      ist_ff <= ist_set | (ist_ff & ~((wr & sel_ist) ? pwdata[`PSR_INT_W-1:0] : '0));
      irq_ff <= |(ist_ff & imsk_ff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_ff <= 1'b0;
      clk_oe_n_ff <= 1'b1;
    end else begin
      clk_out_ff <= 1'b0;
      clk_oe_n_ff <= (state_ff != st_hold);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_par;
    tenth && ctrl_ff.par_mode == `PSR_PAR_ODD && !par_xor |=>
      stat_ff.parity_error_flag && stat_ff.receive_timeout_flag && state_ff == st_hold;
  endproperty
  a_par: assert property (p_par) else $error("parity error not flagged");

  property p_hold_min;
    state_ff == st_hold && (hold_tmr_ff != HOLD_LIM || !read_seen_ff) |=>
      state_ff == st_hold;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("hold ended early");

  property p_hold_pin;
    $rose(state_ff == st_hold) |=> !ps2_clk_oe_n [*2];
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("clock not held low");

  property p_bit_tmo;
    recv && en && !fall && bit_tmr_ff == BIT_LIM |=> stat_ff.receive_timeout_flag;
  endproperty
  a_bit_tmo: assert property (p_bit_tmo) else $error("bit timeout missed");

  property p_frame_tmo;
    recv && en && !fall && cnt_ff < `PSR_CNT_PAR && frame_tmr_ff == FRAME_LIM |=>
      state_ff == st_hold;
  endproperty
  a_frame_tmo: assert property (p_frame_tmo) else $error("frame timeout missed");

  property p_stop;
    stop_err |=> stat_ff.framing_error_flag && stat_ff.receive_timeout_flag && ist_ff[2];
  endproperty
  a_stop: assert property (p_stop) else $error("framing error not flagged");

  property p_en_gate;
    !en |=> !$rose(stat_ff.receive_timeout_flag);
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("timeout while disabled");

  property p_act;
    $rose(stat_ff.receive_timeout_flag) || $rose(stat_ff.byte_ready) |-> ist_ff[0];
  endproperty
  a_act: assert property (p_act) else $error("activity not raised");

  property p_ready;
    eleventh && !stop_err |=> stat_ff.byte_ready && state_ff == st_idle;
  endproperty
  a_ready: assert property (p_ready) else $error("byte ready missed");

  property p_rd_clr;
    rd && sel_data && !rdy_ev |=> !stat_ff.byte_ready;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("byte ready not cleared");

  property p_w1c;
    w1c && pwdata[`PSR_ST_PE] && !par_err |=> !stat_ff.parity_error_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("parity error not cleared");
endmodule // psr_rx_status

// File: inc/psr_params.svh
// Constants for the PS/2 receive status block
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH
`define PSR_AW 12
`define PSR_OFS_DATA 12'h000
`define PSR_OFS_CTRL 12'h004
`define PSR_OFS_STAT 12'h008
`define PSR_OFS_IST 12'h00C
`define PSR_OFS_IMSK 12'h010
`define PSR_CLK_MHZ 50
`define PSR_BIT_US 300
`define PSR_FRAME_MS 2
`define PSR_HOLD_US 300
`define PSR_TW 17
`define PSR_CNT_START 4'h1
`define PSR_CNT_LAST_DATA 4'h8
`define PSR_CNT_PAR 4'h9
`define PSR_CNT_STOP 4'hA
`define PSR_ST_RDY 0
`define PSR_ST_TMO 1
`define PSR_ST_PE 2
`define PSR_ST_FE 3
`define PSR_ST_BUSY 6
`define PSR_CTRL_W 5
`define PSR_INT_W 3
`define PSR_PAR_NONE 2'h0
`define PSR_PAR_EVEN 2'h1
`define PSR_PAR_ODD 2'h2
`define PSR_STOP_HIGH 2'h1
`define PSR_STOP_LOW 2'h2
`endif

// File: inc/psr_pkg.sv
// Types for the PS/2 receive status block
package psr_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_recv = 3'h2,
    st_hold = 3'h4
  } psr_state_t;
  typedef struct packed {
    logic [1:0] stop_mode;
    logic [1:0] par_mode;
    logic channel_enable;
  } psr_ctrl_t;
  typedef struct packed {
    logic framing_error_flag;
    logic parity_error_flag;
    logic receive_timeout_flag;
    logic byte_ready;
  } psr_stat_t;
endpackage

// File: tb/psr_kbd.sv
// PS/2 peripheral model driving the clock and data lines
`timescale 1ns/1ns
module psr_kbd (
  input wire logic pclk,
  output logic kbd_clk,
  output logic kbd_dat
);
  // Half link clock in system clocks, for a 160 ns link clock
  localparam int HALF = 4;
  initial begin
    kbd_clk = 1'b1;
    kbd_dat = 1'b1;
  end
  // Frame of nf bits; bit late is stretched by ext cycles; clock idles high
  task automatic send(input logic [7:0] b, input logic par, input logic stp,
                      input int ext, input int late, input int nf);
    logic [10:0] fr;
    fr = {stp, par, b, 1'b0};
    for (int i = 0; i < nf; i++) begin
      kbd_dat <= fr[i];
      repeat (HALF + ((i == late) ? ext : 0)) @(posedge pclk);
      kbd_clk <= 1'b0;
      repeat (HALF) @(posedge pclk);
      kbd_clk <= 1'b1;
    end
    repeat (HALF) @(posedge pclk);
    kbd_dat <= 1'b1;
  endtask
endmodule // psr_kbd

// File: tb/tb_psr_rx_status.sv
// Self-checking bench for the PS/2 receive status block
`timescale 1ns/1ns
`include "psr_params.svh"
module tb_psr_rx_status;
  import psr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`PSR_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, ps2_clk_out, ps2_clk_oe_n, irq, kbd_clk, kbd_dat, err;
  int n_fail = 0;
  int tests_run = 0;
  always #10 pclk = ~pclk;
  psr_rx_status #(.BIT_CYC(40), .FRAME_CYC(90), .HOLD_CYC(30)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .ps2_clk_in(kbd_clk & (ps2_clk_oe_n | ps2_clk_out)), .ps2_dat_in(kbd_dat),
    .ps2_clk_out(ps2_clk_out), .ps2_clk_oe_n(ps2_clk_oe_n), .irq(irq)
  );
  psr_kbd i_kbd (.pclk(pclk), .kbd_clk(kbd_clk), .kbd_dat(kbd_dat));
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // Clock hold must end once status was read and the minimum passed
  task automatic wait_free();
    int k;
    k = 0;
    while (ps2_clk_oe_n !== 1'b1 && k < 60) begin
      @(posedge pclk);
      k++;
    end
    chk("oe_n free", 1'b1, ps2_clk_oe_n);
    apb(1'b1, `PSR_OFS_STAT, 32'h0000_000E);
    apb(1'b1, `PSR_OFS_IST, 32'h0000_0007);
  endtask
  task automatic t_reset();
    rchk("stat", `PSR_OFS_STAT, 4'h0);
    rchk("ctrl", `PSR_OFS_CTRL, 4'h0);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("slverr", 1'b1, err);
    chk("oe_n", 1'b1, ps2_clk_oe_n);
    chk("irq", 1'b0, irq);
    $display("test reset done");
  endtask
  task automatic t_good();
    apb(1'b1, `PSR_OFS_CTRL, 32'h0000_000B);
    apb(1'b1, `PSR_OFS_IMSK, 32'h0000_0001);
    i_kbd.send(8'hA5, 1'b0, 1'b1, 0, 99, 11);
    repeat (8) @(posedge pclk);
    chk("irq", 1'b1, irq);
    rchk("stat", `PSR_OFS_STAT, 4'h1);
    apb(1'b1, `PSR_OFS_STAT, 32'h0000_0001);
    rchk("stat ro", `PSR_OFS_STAT, 4'h1);
    rchk("data", `PSR_OFS_DATA, 8'hA5);
    rchk("stat rd", `PSR_OFS_STAT, 4'h0);
    apb(1'b1, `PSR_OFS_IST, 32'h0000_0007);
    repeat (3) @(posedge pclk);
    chk("irq clr", 1'b0, irq);
    $display("test good frame done");
  endtask
  task automatic t_par();
    apb(1'b1, `PSR_OFS_CTRL, 32'h0000_000D);
    apb(1'b1, `PSR_OFS_IMSK, 32'h0000_0007);
    i_kbd.send(8'h3C, 1'b0, 1'b1, 0, 99, 11);
    repeat (8) @(posedge pclk);
    chk("oe_n", 1'b0, ps2_clk_oe_n);
    chk("clk_out", 1'b0, ps2_clk_out);
    chk("irq", 1'b1, irq);
    repeat (40) @(posedge pclk);
    chk("oe_n unread", 1'b0, ps2_clk_oe_n);
    rchk("stat", `PSR_OFS_STAT, 4'h6);
    wait_free();
    rchk("stat w1c", `PSR_OFS_STAT, 4'h0);
    $display("test parity done");
  endtask
  task automatic t_stop();
    apb(1'b1, `PSR_OFS_CTRL, 32'h0000_0013);
    i_kbd.send(8'h01, 1'b1, 1'b1, 0, 99, 11);
    repeat (8) @(posedge pclk);
    rchk("stat", `PSR_OFS_STAT, 4'hA);
    repeat (6) @(posedge pclk);
    chk("oe_n min", 1'b0, ps2_clk_oe_n);
    wait_free();
    $display("test stop done");
  endtask
  task automatic t_tmo(input int ext, input int late);
    apb(1'b1, `PSR_OFS_CTRL, 32'h0000_0001);
    i_kbd.send(8'h55, 1'b0, 1'b1, ext, late, 11);
    repeat (8) @(posedge pclk);
    rchk("stat", `PSR_OFS_STAT, 4'h2);
    wait_free();
    $display("test timeout done");
  endtask
  task automatic t_dis();
    apb(1'b1, `PSR_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, `PSR_OFS_IMSK, 32'h0000_0000);
    i_kbd.send(8'h55, 1'b0, 1'b1, 50, 4, 11);
    repeat (8) @(posedge pclk);
    chk("oe_n", 1'b1, ps2_clk_oe_n);
    rchk("stat", `PSR_OFS_STAT, 4'h0);
    apb(1'b1, `PSR_OFS_CTRL, 32'h0000_0001);
    i_kbd.send(8'h81, 1'b0, 1'b1, 0, 99, 10);
    apb(1'b1, `PSR_OFS_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    rchk("stat", `PSR_OFS_STAT, 4'h1);
    chk("irq masked", 1'b0, irq);
    apb(1'b1, `PSR_OFS_IMSK, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk("irq", 1'b1, irq);
    rchk("data", `PSR_OFS_DATA, 8'h81);
    wait_free();
    $display("test disable done");
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    results();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_good();
    t_par();
    t_stop();
    t_tmo(50, 4);
    t_tmo(30, 6);
    t_dis();
    results();
  end
endmodule // tb_psr_rx_status
